// ==== common/lcgfs_pkg.sv ====
// Constants, types and register map of the LED channel gate and fault sequencer
package lcgfs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS       = 20;
    localparam int TICK_NS      = 3200;
    localparam int TICK_CYC     = TICK_NS / CLK_NS;
    localparam int UNIT_NS      = 13000;
    localparam int UNIT_TICKS   = 4;
    localparam int SETTLE_NS    = 13000;
    localparam int SETTLE_TICKS = (SETTLE_NS + TICK_NS - 1) / TICK_NS;
    localparam int QUAL_NS      = 13000;
    localparam int QUAL_TICKS   = (QUAL_NS + TICK_NS - 1) / TICK_NS;
    localparam int IND_KHZ      = 80;
    localparam int IND_NS       = 1000000 / IND_KHZ;
    localparam int IND_CYC      = IND_NS / CLK_NS;

    localparam logic [7:0] TICK_LAST   = 8'(TICK_CYC - 1);
    localparam logic [2:0] SETTLE_MAX  = 3'(SETTLE_TICKS);
    localparam logic [2:0] QUAL_LAST   = 3'(QUAL_TICKS - 1);
    localparam logic [9:0] IND_LAST    = 10'(IND_CYC - 1);
    localparam logic [9:0] IND_LOW_Q   = 10'(IND_CYC / 4);
    localparam logic [9:0] IND_LOW_H   = 10'(IND_CYC / 2);
    localparam logic [9:0] IND_LOW_3Q  = 10'((IND_CYC * 3) / 4);
    localparam logic [9:0] IND_LOW_F   = 10'(IND_CYC);

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NCH   = 8;
    localparam int NCTRL = 4;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] REG_MODE   = 12'h000;
    localparam logic [11:0] REG_FAULT  = 12'h004;
    localparam logic [11:0] REG_STAT   = 12'h008;
    localparam int          LOD_LSB    = 0;
    localparam int          LSD_LSB    = 8;
    localparam int          FOD_LSB    = 16;
    localparam int          FSD_LSB    = 24;
    localparam int          OT_BIT     = 0;
    localparam int          EN_BIT     = 1;
    localparam int          GATE_LSB   = 8;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FB_PAIR  = 2'b00,
        FB_FOUR  = 2'b01,
        FB_EIGHT = 2'b10
    } lcgfs_mode_t;

    localparam lcgfs_mode_t MODE_RST = FB_PAIR;

    typedef enum logic [2:0] {
        DUTY_NONE = 3'b000,
        DUTY_Q    = 3'b001,
        DUTY_H    = 3'b010,
        DUTY_3Q   = 3'b011,
        DUTY_FULL = 3'b100
    } lcgfs_duty_t;

    typedef struct packed {
        logic [7:0] drain_low;
        logic [7:0] drain_high_fix;
        logic [7:0] drain_high_adj;
        logic [7:0] src_low;
        logic [7:0] src_over;
        logic [7:0] src_under;
    } lcgfs_sense_t;

endpackage

// ==== sim/lcgfs_host.sv ====
// Host PWM controller model driving enable and control inputs
`timescale 1ns/100ps
module lcgfs_host (
    input  wire logic       clk,
    output logic            en,
    output logic [3:0]      ctrl
);
    import lcgfs_pkg::*;
    initial begin
        en = 1'b0;
        ctrl = 4'h0;
    end
    // hold one tick
    // Each level stands a full tick before the next change
    task automatic set_ctrl(input logic [3:0] v);
        repeat (TICK_CYC) @(posedge clk);
        ctrl <= v;
    endtask
    task automatic set_en(input logic v);
        @(posedge clk);
        en <= v;
        @(posedge clk);
    endtask
endmodule

// ==== sim/lcgfs_top_test.sv ====
// Self-checking bench of the LED gate and fault sequencer
`timescale 1ns/100ps
module lcgfs_top_test;
    import lcgfs_pkg::*;
    logic         clk, rst_b, psel, penable, pwrite, over_temp;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, seed;
    logic         pready, pslverr, reg_off, fault_o, fault_oe, en;
    logic [7:0]   gate;
    logic [3:0]   ctrl;
    lcgfs_sense_t sense;
    logic [32:0]  notes[$];
    int           err_count, checked, cyc, n;

    lcgfs_host host (.clk(clk), .en(en), .ctrl(ctrl));
    lcgfs_top dut (.REF_CLK(clk), .RST_B(rst_b), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EN(en), .CTRL(ctrl), .SENSE(sense),
        .OVER_TEMP(over_temp), .GATE(gate), .REG_OFF(reg_off),
        .FAULT_O(fault_o), .FAULT_OE(fault_oe));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compares %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, s);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Settle one step past the edge so design updates have landed
    task automatic w(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Reads leave the expected word and error flag as a note
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        if (!wr)
            notes.push_back(e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Low cycles of the indicator over one full period
    task automatic duty(input logic [31:0] e);
        int lo;
        lo = 0;
        repeat (IND_CYC) begin
            @(posedge clk);
            lo += 32'(fault_oe);
        end
        chk("low_len", e, 32'(lo));
    endtask

    // ------------------------------------------------------------
    // Clock, watcher, timeout
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk("prdata", notes[0][31:0], prdata);
            chk("pslverr", 32'(notes[0][32]), 32'(pslverr));
            void'(notes.pop_front());
        end
        if (++cyc == 40000) begin
            err_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {rst_b, psel, penable, pwrite, over_temp} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        sense = '0;
        seed = 32'h0001_3F46;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, REG_MODE, 32'h0, 33'h0_0000_0000);
        apb(1'b0, 12'h00C, 32'h0, 33'h1_0000_0000);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            host.set_ctrl(seed[3:0]);
            w(2);
            chk("gate_en_low", 32'h0, 32'(gate));
        end
        host.set_ctrl(4'h0);
        // Flush random history out of the longest delay line
        w(4500);
        host.set_en(1'b1);
        host.set_ctrl(4'h1);
        w(2);
        chk("gate1_on", 32'h01, 32'(gate));
        w(468);
        chk("gate2_wait", 32'h01, 32'(gate));
        w(360);
        chk("gate2_on", 32'h03, 32'(gate));
        host.set_ctrl(4'h0);
        w(2);
        chk("gate1_off", 32'h02, 32'(gate));
        host.set_en(1'b0);
        w(1);
        chk("en_off", 32'h0, 32'(gate));
        apb(1'b1, REG_MODE, 32'h1, 33'h0);
        apb(1'b0, REG_MODE, 32'h0, 33'h0_0000_0001);
        host.set_en(1'b1);
        host.set_ctrl(4'h1);
        w(4700);
        chk("gate_four", 32'h63, 32'(gate));
        host.set_ctrl(4'h0);
        host.set_en(1'b0);
        apb(1'b1, REG_MODE, 32'h0, 33'h0);
        // Four-mode ones must leave the deep delay lines first
        w(4500);
        @(posedge clk);
        sense.drain_low <= 8'h01;
        host.set_en(1'b1);
        host.set_ctrl(4'h1);
        w(2000);
        chk("gate_isolate", 32'h02, 32'(gate));
        apb(1'b0, REG_FAULT, 32'h0, 33'h0_0000_0001);
        w(700);
        duty(32'(IND_LOW_Q));
        @(posedge clk);
        sense.drain_low <= 8'h00;
        host.set_en(1'b0);
        host.set_en(1'b1);
        apb(1'b0, REG_FAULT, 32'h0, 33'h0_0000_0000);
        w(2);
        chk("relit", 32'h1, 32'(gate[0]));
        w(700);
        chk("released", 32'h0, 32'(fault_oe));
        @(posedge clk);
        over_temp <= 1'b1;
        w(3);
        @(posedge clk);
        over_temp <= 1'b0;
        w(3);
        chk("reg_off", 32'h1, 32'(reg_off));
        chk("gate_ot", 32'h0, 32'(gate));
        w(700);
        duty(32'(IND_LOW_F));
        host.set_en(1'b0);
        host.set_en(1'b1);
        w(2);
        chk("reg_on", 32'h0, 32'(reg_off));
        @(posedge clk);
        sense.drain_high_fix <= 8'h01;
        sense.src_low <= 8'h02;
        // Scaled threshold must be ignored in pairing mode
        sense.drain_high_adj <= 8'hFF;
        w(2000);
        apb(1'b0, REG_FAULT, 32'h0, 33'h0_0002_0100);
        w(700);
        duty(32'(IND_LOW_3Q));
        @(posedge clk);
        sense <= '0;
        host.set_en(1'b0);
        host.set_en(1'b1);
        seed = xs(seed);
        @(posedge clk);
        sense.src_over <= seed[7:0] | 8'h01;
        w(3);
        apb(1'b0, REG_FAULT, 32'h0,
            {1'b0, seed[7:0] | 8'h01, 24'h00_0000});
        w(700);
        duty(32'(IND_LOW_F));
        @(posedge clk);
        sense.src_over <= 8'h00;
        sense.src_under <= 8'hFF;
        w(3);
        apb(1'b0, REG_FAULT, 32'h0, 33'h0_0000_0000);
        chk("fault_o", 32'h0, 32'(fault_o));
        close_out();
    end
endmodule

// ==== src/lcgfs_delay_line.sv ====
// Tick-paced shift register giving one gate its phase-shift delay
`timescale 1ns/100ps
module lcgfs_delay_line #(
    parameter int DEPTH = 4
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic tick,
    input  wire logic din,
    output logic      dout
);
    import lcgfs_pkg::*;

    logic [DEPTH-1:0] sr;

    // ------------------------------------------------------------
    // Shift
    // ------------------------------------------------------------
    // Both edges delayed alike
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sr <= '0;
        end else if (tick) begin
            sr <= {sr[DEPTH-2:0], din};
        end
    end

    assign dout = sr[DEPTH-1];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_shift_in;
        tick |=> sr[0] == $past(din);
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("delay line did not capture input on tick");

    property p_hold;
        !tick |=> $stable(sr);
    endproperty
    a_hold: assert property (p_hold)
        else $error("delay line moved without tick");
endmodule

// ==== src/lcgfs_fault_ind.sv ====
// Open-drain fault indicator: fixed period, duty picked by fault class
`timescale 1ns/100ps
module lcgfs_fault_ind (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire lcgfs_pkg::lcgfs_duty_t duty_in,
    output logic                    oe
);
    import lcgfs_pkg::*;

    logic [9:0]  cnt;
    lcgfs_duty_t duty;
    logic [9:0]  low_len;
    logic        next_oe;
    wire         wrap = (cnt == IND_LAST);

    assign low_len = (duty == DUTY_Q)    ? IND_LOW_Q  :
                     (duty == DUTY_H)    ? IND_LOW_H  :
                     (duty == DUTY_3Q)   ? IND_LOW_3Q :
                     (duty == DUTY_FULL) ? IND_LOW_F  : 10'h000;
    // Low for the duty share of the period
    assign next_oe = (duty != DUTY_NONE) && (cnt < low_len);

    // ------------------------------------------------------------
    // Period counter and duty
    // ------------------------------------------------------------
    // Duty taken only at period start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= 10'h000;
            duty <= DUTY_NONE;
            oe   <= 1'b0;
        end else begin
            cnt  <= wrap ? 10'h000 : cnt + 10'h001;
            duty <= wrap ? duty_in : duty;
            oe   <= next_oe;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_duty_hold;
        !wrap |=> $stable(duty);
    endproperty
    a_duty_hold: assert property (p_duty_hold)
        else $error("indicator duty changed mid-period");

    property p_quarter_edge;
        (duty == DUTY_Q && cnt == IND_LOW_Q - 10'h001) |=> oe ##1 !oe;
    endproperty
    a_quarter_edge: assert property (p_quarter_edge)
        else $error("quarter duty low phase has wrong length");

    property p_full_low;
        duty == DUTY_FULL |=> oe;
    endproperty
    a_full_low: assert property (p_full_low)
        else $error("full duty indicator released");

    property p_release;
        duty == DUTY_NONE |=> !oe;
    endproperty
    a_release: assert property (p_release)
        else $error("indicator pulled low with no fault");

    c_half: cover property (duty == DUTY_H && wrap);
endmodule

// ==== src/lcgfs_top.sv ====
// Gate sequencing, fault qualification and APB registers of the LED driver
`timescale 1ns/100ps

// Notes on behaviour
// - Enable low turns every gate off regardless of control inputs.
// - Pairing mode: input k drives gates 2k-1 and 2k.
// - High control input turns on its channels; mapping follows feedback mode.
// - Enable changes reach gates directly, bypassing phase delays.
// - Unit phase delay is four internal clock ticks.
// - Gate n lags its input edge by n-1 unit delays.
// - Turn-on and turn-off edges get the same stagger.
// - Four-converter mode: input 1 drives gates 1,2,6,7; stagger kept.
// - After a channel turns on, wait settle time before sampling comparators.
// - Abnormal comparator must persist for qualify time to become a fault.
// - Failed channel shuts off alone before fault indication starts.
// - Open, short and FET-open faults watched while on; latched, channel off.
// - Indicator runs near 80 kHz; low duty 25/50/75/100 by fault class.
// - LED short threshold: fixed in pairing mode, headroom-scaled otherwise.
// - FET short watched always, not latched, clears below release level.
// - Over-temperature latches, kills all gates and regulator, indicator low.
// - Latched faults clear on enable high-low-high or supply lockout.
// - Reset selects pairing feedback mode.
// - Supply lockout holds all logic in reset.
module lcgfs_top (
    input  wire logic                    REF_CLK,
    input  wire logic                    RST_B,
    input  wire logic                    PSEL,
    input  wire logic                    PENABLE,
    input  wire logic                    PWRITE,
    input  wire logic [11:0]             PADDR,
    input  wire logic [31:0]             PWDATA,
    output logic      [31:0]             PRDATA,
    output logic                         PREADY,
    output logic                         PSLVERR,
    input  wire logic                    EN,
    input  wire logic [3:0]              CTRL,
    input  wire lcgfs_pkg::lcgfs_sense_t SENSE,
    input  wire logic                    OVER_TEMP,
    output logic      [7:0]              GATE,
    output logic                         REG_OFF,
    output logic                         FAULT_O,
    output logic                         FAULT_OE
);
    import lcgfs_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]     div_cnt;
    logic           tick;
    lcgfs_mode_t    mode;
    lcgfs_mode_t    mode_eff;
    logic           en_q;
    logic           ot_l;
    logic [NCH-1:0] src_sel;
    logic [NCH-1:0] dly_out;
    logic [NCH-1:0] lod_v;
    logic [NCH-1:0] lsd_v;
    logic [NCH-1:0] fod_v;
    logic [NCH-1:0] fsd_v;
    logic [NCH-1:0] chan_off;
    logic [NCH-1:0] next_gate;
    lcgfs_duty_t    duty_sel;
    logic [31:0]    rdata_mux;

    // Rising enable after low clears latches
    wire en_rise  = EN & ~en_q;
    wire mode_pair = (mode_eff == FB_PAIR);

    // ------------------------------------------------------------
    // Internal clock tick
    // ------------------------------------------------------------
    // Tick paces all phase delays
    assign tick = (div_cnt == TICK_LAST);

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            div_cnt <= 8'h00;
            en_q    <= 1'b0;
            ot_l    <= 1'b0;
        end else begin
            div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
            en_q    <= EN;
            ot_l    <= (ot_l & ~en_rise) | OVER_TEMP;
        end
    end

    assign REG_OFF = ot_l;

    // ------------------------------------------------------------
    // Mode and input mapping
    // ------------------------------------------------------------
    // Unused code falls back to pairing so gates never lose a source
    assign mode_eff = (mode == FB_FOUR || mode == FB_EIGHT) ? mode : FB_PAIR;
    assign chan_off = lod_v | lsd_v | fod_v;

    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            localparam int PAIR_SRC = i / 2;
            localparam int FOUR_SRC = (i == 0 || i == 1 || i == 5 || i == 6)
                                      ? 0 : 1;
            logic [2:0] settle;
            logic [2:0] qual;
            logic       led_open_fault;
            logic       led_short_fault;
            logic       fet_open_fault;
            logic       fet_short_fault;

            // High input lights its mapped channels
            assign src_sel[i] = (mode_eff == FB_FOUR)  ? CTRL[FOUR_SRC] :
                                (mode_eff == FB_EIGHT) ? CTRL[0] :
                                CTRL[PAIR_SRC];

            // Gate n delayed by n-1 units
            if (i == 0) begin : g_nodly
                assign dly_out[i] = src_sel[i];
            end else begin : g_dly
                lcgfs_delay_line #(
                    .DEPTH (i * UNIT_TICKS)
                ) u_dly (
                    .clk   (REF_CLK),
                    .rst_n (RST_B),
                    .tick  (tick),
                    .din   (src_sel[i]),
                    .dout  (dly_out[i])
                );
            end

            wire drain_hi = mode_pair ? SENSE.drain_high_fix[i]
                                      : SENSE.drain_high_adj[i];
            wire abn   = SENSE.drain_low[i] | drain_hi | SENSE.src_low[i];
            wire watch = GATE[i] && (settle == SETTLE_MAX);
            wire done  = tick && watch && abn && (qual == QUAL_LAST);

            always_ff @(posedge REF_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    settle <= 3'h0;
                    qual   <= 3'h0;
                    led_open_fault    <= 1'b0;
                    led_short_fault    <= 1'b0;
                    fet_open_fault    <= 1'b0;
                    fet_short_fault    <= 1'b0;
                end else begin
                    if (!GATE[i]) begin
                        settle <= 3'h0;
                    end else if (tick && settle != SETTLE_MAX) begin
                        settle <= settle + 3'h1;
                    end
                    if (!(watch && abn) || done) begin
                        qual <= 3'h0;
                    end else if (tick) begin
                        qual <= qual + 3'h1;
                    end
                    led_open_fault <= (led_open_fault & ~en_rise) | (done & SENSE.drain_low[i]);
                    led_short_fault <= (led_short_fault & ~en_rise) | (done & drain_hi);
                    fet_open_fault <= (fet_open_fault & ~en_rise) | (done & SENSE.src_low[i]);
                    if (SENSE.src_over[i]) begin
                        fet_short_fault <= 1'b1;
                    end else if (SENSE.src_under[i]) begin
                        fet_short_fault <= 1'b0;
                    end
                end
            end

            assign lod_v[i] = led_open_fault;
            assign lsd_v[i] = led_short_fault;
            assign fod_v[i] = fet_open_fault;
            assign fsd_v[i] = fet_short_fault;

            p_settle: assert property (@(posedge REF_CLK) disable iff (!RST_B)
                qual != 3'h0 |-> settle == SETTLE_MAX)
                else $error("comparator qualified before settle time");

            p_qual: assert property (@(posedge REF_CLK) disable iff (!RST_B)
                $rose(chan_off[i]) |-> $past(qual) == QUAL_LAST
                && $past(tick) && $past(GATE[i]))
                else $error("fault latched without full qualification");
        end
    endgenerate

    // ------------------------------------------------------------
    // Gate drive
    // ------------------------------------------------------------
    // Enable gates every channel; not delayed
    assign next_gate = {NCH{EN & ~ot_l}} & dly_out & ~chan_off;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            GATE <= 8'h00;
        end else begin
            GATE <= next_gate;
        end
    end

    // ------------------------------------------------------------
    // Fault indication
    // ------------------------------------------------------------
    // Most severe class wins
    assign duty_sel = (ot_l || |fsd_v) ? DUTY_FULL :
                      (|fod_v)         ? DUTY_3Q   :
                      (|lsd_v)         ? DUTY_H    :
                      (|lod_v)         ? DUTY_Q    : DUTY_NONE;

    lcgfs_fault_ind u_ind (
        .clk     (REF_CLK),
        .rst_n   (RST_B),
        .duty_in (duty_sel),
        .oe      (FAULT_OE)
    );

    assign FAULT_O = 1'b0;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    wire setup  = PSEL & ~PENABLE;
    wire access = PSEL & PENABLE;
    wire hit_mode  = (PADDR == REG_MODE);
    wire hit_fault = (PADDR == REG_FAULT);
    wire hit_stat  = (PADDR == REG_STAT);
    wire hit       = hit_mode | hit_fault | hit_stat;

    always_comb begin
        rdata_mux = RDATA_ZERO;
        if (hit_mode) begin
            rdata_mux[1:0] = mode;
        end else if (hit_fault) begin
            rdata_mux[LOD_LSB +: NCH] = lod_v;
            rdata_mux[LSD_LSB +: NCH] = lsd_v;
            rdata_mux[FOD_LSB +: NCH] = fod_v;
            rdata_mux[FSD_LSB +: NCH] = fsd_v;
        end else if (hit_stat) begin
            rdata_mux[OT_BIT]          = ot_l;
            rdata_mux[EN_BIT]          = EN;
            rdata_mux[GATE_LSB +: NCH] = GATE;
        end
    end

    assign PREADY  = 1'b1;
    assign PSLVERR = access & ~hit;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode   <= MODE_RST;
            PRDATA <= RDATA_ZERO;
        end else begin
            if (access && PWRITE && hit_mode) begin
                mode <= lcgfs_mode_t'(PWDATA[1:0]);
            end
            if (setup && !PWRITE) begin
                PRDATA <= rdata_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    property p_en_off;
        !EN |=> GATE == 8'h00;
    endproperty
    a_en_off: assert property (p_en_off)
        else $error("gate on while enable low");

    property p_en_fall;
        $fell(EN) |=> GATE == 8'h00;
    endproperty
    a_en_fall: assert property (p_en_fall)
        else $error("enable fall not applied at once");

    property p_pair_first;
        (EN && mode_eff == FB_PAIR && !ot_l && !chan_off[0])
            |=> GATE[0] == $past(CTRL[0]);
    endproperty
    a_pair_first: assert property (p_pair_first)
        else $error("gate 1 not following input 1");

    property p_four_map;
        mode_eff == FB_FOUR |-> src_sel[5] == CTRL[0] && src_sel[2] == CTRL[1];
    endproperty
    a_four_map: assert property (p_four_map)
        else $error("four-converter mapping wrong");

    property p_tick;
        tick |=> !tick [*8];
    endproperty
    a_tick: assert property (p_tick)
        else $error("internal tick too frequent");

    property p_off_latched;
        |chan_off |=> (GATE & $past(chan_off)) == 8'h00;
    endproperty
    a_off_latched: assert property (p_off_latched)
        else $error("faulted channel still driven");

    property p_ot;
        OVER_TEMP |=> ot_l && REG_OFF ##1 GATE == 8'h00;
    endproperty
    a_ot: assert property (p_ot)
        else $error("over-temperature shutdown missing");

    property p_clear;
        en_rise |=> chan_off == 8'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("latched faults survived enable toggle");

    property p_sev;
        (ot_l || |fsd_v) |-> duty_sel == DUTY_FULL;
    endproperty
    a_sev: assert property (p_sev)
        else $error("severe fault not shown at full duty");

    property p_fsd_rel;
        (SENSE.src_under[0] && !SENSE.src_over[0]) |=> !fsd_v[0];
    endproperty
    a_fsd_rel: assert property (p_fsd_rel)
        else $error("short fault did not release");

    c_latch: cover property ($rose(|chan_off));
    c_fsd:   cover property ($rose(|fsd_v));
    c_ot:    cover property ($rose(ot_l));
    c_four:  cover property (mode_eff == FB_FOUR && GATE[6]);
endmodule
